//--- dv/board_strap_config_decode_properties.sv
`timescale 1ns/10ps
`default_nettype none
module board_strap_config_decode_properties
  import strap_cfg_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_strobe_i,
  input wire logic bus_read_i,
  input wire logic board_select_o,
  input wire logic [15:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic [7:0] base_address_strap_field_i,
  input wire logic [6:0] scan_length_strap_field_i,
  input wire logic [4:0] config_readback_strap_field_i,
  input wire logic ext_trigger_enable_i,
  input wire logic trigger_input_strap_i,
  input wire logic ext_trigger_n_i,
  input wire logic trigger_ready_out_o,
  input wire logic conv_start_o,
  input wire logic [5:0] channel_o,
  input wire logic scan_active_o,
  input wire logic scan_done_o
);
  logic [5:0] last;
  // all straps open is length zero, run as one
  assign last = &scan_length_strap_field_i ? 6'h00 : 6'(~scan_length_strap_field_i) - 6'h01;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  base_select_a: assert property (
    board_select_o |-> bus_strobe_i && bus_addr_i[15:8] == base_address_strap_field_i)
    else $error("bad select");
  read_answer_a: assert property (
    board_select_o && bus_read_i |=> read_valid_o) else $error("no answer");
  read_refuse_a: assert property (
    !board_select_o |=> !read_valid_o) else $error("stray answer");
  readback_a: assert property (
    board_select_o && bus_read_i && bus_addr_i[7:0] == CFG_READBACK_OFFSET |=>
    read_data_o == {CFG_FIXED_BITS, $past(config_readback_strap_field_i)})
    else $error("bad readback");
  ready_out_a: assert property (
    trigger_ready_out_o == ext_trigger_enable_i) else $error("bad ready");
  trig_start_a: assert property (
    $fell(ext_trigger_n_i) && ext_trigger_enable_i && !trigger_input_strap_i
    && !scan_active_o |=> conv_start_o) else $error("trigger lost");
  scan_len_a: assert property (
    scan_done_o |-> $past(channel_o) == last) else $error("bad length");
  scan_wrap_a: assert property (
    scan_done_o |-> channel_o == CHAN_ZERO) else $error("no wrap");
  cover property (scan_done_o);
  cover property (read_valid_o && read_data_o != 16'h0000);
  cover property ($fell(ext_trigger_n_i) && trigger_ready_out_o);
endmodule
bind board_strap_config_decode board_strap_config_decode_properties chk (.*);
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import strap_cfg_pkg::*;
;
  logic clk_i, rst_i, bus_strobe_i, bus_read_i, board_select_o, read_valid_o, fire;
  logic either_access_strap_i, nonpriv_access_strap_i, trigger_input_strap_i, soft_start_i;
  logic ext_trigger_enable_i, timer_load_i, conv_done_i, ext_trigger_n_i, trigger_ready_out_o;
  logic conv_start_o, scan_active_o, scan_done_o;
  logic [15:0] bus_addr_i, read_data_o, timer_reload_i [3];
  logic [7:0] sub_addr_o, base_address_strap_field_i;
  logic [6:0] scan_length_strap_field_i;
  logic [5:0] bus_am_i, channel_o;
  logic [4:0] config_readback_strap_field_i, cfg [5] = '{5'h02, 5'h04, 5'h10, 5'h08, 5'h1F};
  logic [8:0] am_tab [7] = '{9'h1DB, 9'h1D2, 9'h0D3, 9'h0DB, 9'h153, 9'h15A, 9'h05B};
  logic [2:0] timer_chain_strap_field_i;
  op_mode_e op_mode_i;
  int n_errors, n_checks, ns, nd;
  board_strap_config_decode dut (.*);
  trigger_source far_end (
    .clk_i(clk_i),
    .ready_i(trigger_ready_out_o),
    .fire_i(fire),
    .trig_n_o(ext_trigger_n_i)
  );
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    n_checks++;
    if (v !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // entered at an edge; request stands for exactly one sampling edge
  task automatic acc(input logic [15:0] a, input logic [5:0] m, input logic s,
    input logic [15:0] d);
    bus_addr_i <= a;
    bus_am_i <= m;
    bus_strobe_i <= 1'b1;
    #1 chk(16'(board_select_o), 16'(s));
    chk(16'(sub_addr_o), {8'h00, a[7:0]});
    @(posedge clk_i);
    bus_strobe_i <= 1'b0;
    #1 chk(16'(read_valid_o), 16'(s));
    if (s)
      chk(read_data_o, d);
    @(posedge clk_i);
  endtask
  task automatic scan(input op_mode_e m, input logic [6:0] ls, input logic t, input int c);
    @(posedge clk_i);
    op_mode_i <= m;
    scan_length_strap_field_i <= ls;
    trigger_input_strap_i <= t;
    fire <= 1'b1;
    ns = 0;
    nd = 0;
    repeat (c)
    begin
      @(posedge clk_i);
      fire <= 1'b0;
      #1 ns += int'(conv_start_o);
      nd += int'(scan_done_o);
    end
    $display("scan test mode %0d done", m);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    conv_done_i <= conv_start_o;
  initial
  begin
    // well above the whole sequence, well below the cycle budget
    #400000;
    n_errors++;
    test_done();
  end
  initial
  begin
    // conv_done_i has the converter model as its only driver
    {rst_i, bus_read_i, bus_strobe_i, fire, soft_start_i, timer_load_i} = 6'h30;
    {bus_addr_i, bus_am_i, timer_chain_strap_field_i} = 25'h0000007;
    timer_reload_i = '{default: 16'h0010};
    {either_access_strap_i, nonpriv_access_strap_i, trigger_input_strap_i} = 3'h7;
    ext_trigger_enable_i = 1'b1;
    base_address_strap_field_i = 8'h85;
    scan_length_strap_field_i = 7'h7C;
    config_readback_strap_field_i = 5'h00;
    op_mode_i = MODE_SCAN_ONCE;
    n_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (cfg[i])
    begin
      config_readback_strap_field_i <= cfg[i];
      acc(16'h850E, AM_SHORT_SUPER, 1'b1, {11'h000, cfg[i]});
    end
    acc(16'h8500, AM_SHORT_SUPER, 1'b1, 16'h0000);
    foreach (am_tab[i])
    begin
      {either_access_strap_i, nonpriv_access_strap_i} <= am_tab[i][8:7];
      acc(16'h850E, am_tab[i][6:1], am_tab[i][0], 16'h001F);
    end
    acc(16'h840E, AM_SHORT_SUPER, 1'b0, 16'h0000);
    ext_trigger_enable_i <= 1'b0;
    #1 chk(16'(trigger_ready_out_o), 16'h0000);
    @(posedge clk_i);
    ext_trigger_enable_i <= 1'b1;
    $display("bus test done");
    scan(MODE_SCAN_ONCE, 7'h7C, 1'b1, 40);
    chk(16'(ns), 16'h0000);
    scan(MODE_SCAN_ONCE, 7'h7C, 1'b0, 40);
    chk(16'(ns), 16'h0003);
    chk(16'(nd), 16'h0001);
    chk(16'(scan_active_o), 16'h0000);
    chk(16'(channel_o), 16'h0000);
    scan(MODE_SCAN_ONCE, 7'h3F, 1'b0, 200);
    chk(16'(ns), 16'h0040);
    chk(16'(nd), 16'h0001);
    scan(MODE_SINGLE, 7'h7C, 1'b0, 40);
    chk(16'(ns), 16'h0001);
    // 16-bit chain, reload 16: one start every 17 cycles
    @(posedge clk_i);
    timer_chain_strap_field_i <= 3'h3;
    scan(MODE_SINGLE, 7'h7C, 1'b1, 170);
    chk(16'(ns), 16'h000A);
    @(posedge clk_i);
    timer_chain_strap_field_i <= 3'h7;
    // let a last timer conversion drain before the soft start
    repeat (4) @(posedge clk_i);
    soft_start_i <= 1'b1;
    @(posedge clk_i);
    soft_start_i <= 1'b0;
    #1 chk(16'(conv_start_o), 16'h0001);
    scan(MODE_SCAN_CONTINUOUS, 7'h7D, 1'b0, 40);
    chk(16'(nd >= 2), 16'h0001);
    chk(16'(scan_active_o), 16'h0001);
    test_done();
  end
endmodule
`default_nettype wire

//--- dv/trigger_source.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_source (
  // clock, request and line
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic fire_i,
  output logic trig_n_o = 1'b1
);
  logic [1:0] hold = 2'h0;
  // request dropped unless ready; line pulled up when released
  always @(posedge clk_i)
  begin
    hold <= (hold != 2'h0) ? hold - 2'h1 : {fire_i && ready_i, 1'b0};
    trig_n_o <= hold == 2'h0 && !(fire_i && ready_i);
  end
endmodule
`default_nettype wire

//--- rtl/board_strap_config_decode.sv
// Function
// - access-mode straps pick accepted privilege levels
// - select when A15..A08 match base straps
// - board fills one 256-byte short block
// - low trigger starts conversion or scan
// - trigger ignored unless enabled and strapped
// - trigger-ready output follows enable bit
// - three 16-bit stages, strap picks start
// - scan from channel zero; scan-once stops at length, continuous restarts
// - scan length from seven inverted straps
// - length sixty-four covers channels 0..63
// - bit 4 shows polarity strap
// - bit 3 shows range strap
// - bits 2..0 show gain straps
// - fitted strap reads zero, rest fixed
`timescale 1ns/10ps
`default_nettype none
module board_strap_config_decode
  import strap_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus slave cycle
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [5:0] bus_am_i,
  input wire logic bus_strobe_i,
  input wire logic bus_read_i,
  output logic board_select_o,
  output logic [SUB_W-1:0] sub_addr_o,
  output logic [REG_W-1:0] read_data_o,
  output logic read_valid_o,
  // straps, high means open
  input wire logic [BASE_W-1:0] base_address_strap_field_i,
  input wire logic either_access_strap_i,
  input wire logic nonpriv_access_strap_i,
  input wire logic [SCAN_LEN_W-1:0] scan_length_strap_field_i,
  input wire logic [STAGES-1:0] timer_chain_strap_field_i,
  input wire logic [CFG_STRAP_W-1:0] config_readback_strap_field_i,
  input wire logic trigger_input_strap_i,
  // control from the control register, done strobe from the converter
  input wire logic ext_trigger_enable_i,
  input wire op_mode_e op_mode_i,
  input wire logic soft_start_i,
  input wire logic timer_load_i,
  input wire logic [STAGE_W-1:0] timer_reload_i [STAGES],
  input wire logic conv_done_i,
  // external trigger link
  input wire logic ext_trigger_n_i,
  output logic trigger_ready_out_o,
  // converter sequencing
  output logic conv_start_o,
  output logic [CHAN_W-1:0] channel_o,
  output logic scan_active_o,
  output logic scan_done_o
);
  logic am_ok;
  logic selected;
  logic trig_armed;
  logic trig_prev_n;
  logic next_trig_prev_n;
  logic trig_fire;
  logic timer_fire;
  logic start_req;
  logic [STAGES-1:0] wraps;
  logic [STAGES-1:0] ticks;
  logic [SCAN_LEN_W-1:0] scan_len;
  logic [SCAN_LEN_W-1:0] done_cnt;
  logic [SCAN_LEN_W-1:0] next_done_cnt;
  logic [CHAN_W-1:0] channel;
  logic [CHAN_W-1:0] next_channel;
  logic busy;
  logic next_busy;
  logic scanning;
  logic next_scanning;
  logic conv_start;
  logic next_conv_start;
  logic scan_done;
  logic next_scan_done;
  logic [REG_W-1:0] rdata;
  logic [REG_W-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  // privilege filter; both straps fitted behaves as either
  always_comb
  begin
    am_ok = 1'b0;
    if (!either_access_strap_i)
    begin
      am_ok = (bus_am_i == AM_SHORT_SUPER) || (bus_am_i == AM_SHORT_NONPRIV);
    end
    else if (!nonpriv_access_strap_i)
    begin
      am_ok = (bus_am_i == AM_SHORT_NONPRIV);
    end
    else
    begin
      am_ok = (bus_am_i == AM_SHORT_SUPER);
    end
  end

  assign selected = bus_strobe_i && am_ok &&
    (bus_addr_i[ADDR_BLOCK_MSB:ADDR_BLOCK_LSB] == base_address_strap_field_i);
  assign board_select_o = selected;
  assign sub_addr_o = bus_addr_i[ADDR_BLOCK_LSB-1:0];

  // readback: fitted strap gives zero, straps wired straight through
  always_comb
  begin
    next_rdata = BUS_IDLE_DATA;
    next_rvalid = 1'b0;
    if (selected && bus_read_i)
    begin
      next_rvalid = 1'b1;
      if (sub_addr_o == CFG_READBACK_OFFSET)
      begin
        next_rdata = {CFG_FIXED_BITS, config_readback_strap_field_i};
      end
    end
  end

  // trigger path
  assign trig_armed = ext_trigger_enable_i && !trigger_input_strap_i;
  assign trigger_ready_out_o = ext_trigger_enable_i;
  // falling edge so a held-low trigger starts one run, not a stream
  assign trig_fire = trig_armed && trig_prev_n && !ext_trigger_n_i;
  always_comb
  begin
    next_trig_prev_n = ext_trigger_n_i;
  end

  // timer chain: stage k ticks on wrap of stage k-1
  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : g_stage
      if (g == 0)
      begin : g_first
        assign ticks[g] = 1'b1;
      end
      else
      begin : g_rest
        assign ticks[g] = wraps[g-1];
      end
      timer_stage u_stage (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(timer_load_i),
        .reload_i(timer_reload_i[g]),
        .tick_i(ticks[g]),
        .count_o(),
        .wrap_o(wraps[g])
      );
    end
  endgenerate

  // fitted chain strap picks the stage that starts conversions
  always_comb
  begin
    timer_fire = 1'b0;
    if (!timer_chain_strap_field_i[CHAIN_16])
    begin
      timer_fire = wraps[0];
    end
    else if (!timer_chain_strap_field_i[CHAIN_32])
    begin
      timer_fire = wraps[1];
    end
    else if (!timer_chain_strap_field_i[CHAIN_48])
    begin
      timer_fire = wraps[2];
    end
  end

  assign start_req = trig_fire || timer_fire || soft_start_i;
  assign scan_len = ~scan_length_strap_field_i;

  // sequencer; a zero length is treated as one channel
  always_comb
  begin
    next_channel = channel;
    next_done_cnt = done_cnt;
    next_busy = busy;
    next_scanning = scanning;
    next_conv_start = 1'b0;
    next_scan_done = 1'b0;
    if (!busy)
    begin
      if (start_req || (op_mode_i == MODE_SCAN_CONTINUOUS && !scanning))
      begin
        next_busy = 1'b1;
        next_conv_start = 1'b1;
        next_scanning = (op_mode_i != MODE_SINGLE);
        next_channel = (op_mode_i != MODE_SINGLE) ? CHAN_ZERO : channel;
        next_done_cnt = SCAN_ONE;
      end
    end
    else if (conv_done_i)
    begin
      if (!scanning)
      begin
        next_busy = 1'b0;
      end
      else if (done_cnt >= scan_len)
      begin
        next_scan_done = 1'b1;
        next_channel = CHAN_ZERO;
        if (op_mode_i == MODE_SCAN_CONTINUOUS)
        begin
          next_conv_start = 1'b1;
          next_done_cnt = SCAN_ONE;
        end
        else
        begin
          next_busy = 1'b0;
          next_scanning = 1'b0;
        end
      end
      else
      begin
        next_channel = channel + 6'h01;
        next_done_cnt = done_cnt + SCAN_ONE;
        next_conv_start = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel <= CHAN_ZERO;
      done_cnt <= '0;
      busy <= 1'b0;
      scanning <= 1'b0;
      conv_start <= 1'b0;
      scan_done <= 1'b0;
      rdata <= BUS_IDLE_DATA;
      rvalid <= 1'b0;
      trig_prev_n <= 1'b1;
    end
    else
    begin
      channel <= next_channel;
      done_cnt <= next_done_cnt;
      busy <= next_busy;
      scanning <= next_scanning;
      conv_start <= next_conv_start;
      scan_done <= next_scan_done;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      trig_prev_n <= next_trig_prev_n;
    end
  end

  assign conv_start_o = conv_start;
  assign channel_o = channel;
  assign scan_active_o = scanning;
  assign scan_done_o = scan_done;
  assign read_data_o = rdata;
  assign read_valid_o = rvalid;
endmodule
`default_nettype wire

//--- rtl/strap_cfg_pkg.sv
package strap_cfg_pkg;
  // strap fields: a fitted strap reads as zero
  localparam int BASE_W = 8;
  localparam int SCAN_LEN_W = 7;
  localparam int CHAN_W = 6;
  localparam int STAGE_W = 16;
  localparam int STAGES = 3;
  localparam int CFG_STRAP_W = 5;
  localparam int REG_W = 16;
  localparam int ADDR_BLOCK_LSB = 8;
  localparam int ADDR_BLOCK_MSB = 15;
  localparam int ADDR_W = 16;
  localparam int SUB_W = 8;
  // on-board offset of the readback register inside the block
  localparam logic [SUB_W-1:0] CFG_READBACK_OFFSET = 8'h0E;
  // fixed upper bits of the readback register
  localparam logic [REG_W-CFG_STRAP_W-1:0] CFG_FIXED_BITS = 11'h000;
  localparam logic [REG_W-1:0] BUS_IDLE_DATA = 16'h0000;
  // address modifier codes for short I/O
  localparam logic [5:0] AM_SHORT_SUPER = 6'h2D;
  localparam logic [5:0] AM_SHORT_NONPRIV = 6'h29;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 6'h00;
  localparam logic [SCAN_LEN_W-1:0] SCAN_ONE = 7'h01;
  localparam logic [STAGE_W-1:0] STAGE_ZERO = 16'h0000;
  // timer chain strap index per chain length
  localparam int CHAIN_16 = 2;
  localparam int CHAIN_32 = 1;
  localparam int CHAIN_48 = 0;
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SCAN_ONCE,
    MODE_SCAN_CONTINUOUS
  } op_mode_e;
endpackage

//--- rtl/timer_stage.sv
`timescale 1ns/10ps
`default_nettype none
module timer_stage
  import strap_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [STAGE_W-1:0] reload_i,
  input wire logic tick_i,
  // status
  output logic [STAGE_W-1:0] count_o,
  output logic wrap_o
);
  logic [STAGE_W-1:0] count;
  logic [STAGE_W-1:0] next_count;
  logic wrap;
  logic next_wrap;

  // reload on reaching zero gives a period of reload+1 ticks
  always_comb
  begin
    next_count = count;
    next_wrap = 1'b0;
    if (load_i)
    begin
      next_count = reload_i;
    end
    else if (tick_i)
    begin
      if (count == STAGE_ZERO)
      begin
        next_count = reload_i;
        next_wrap = 1'b1;
      end
      else
      begin
        next_count = count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= STAGE_ZERO;
      wrap <= 1'b0;
    end
    else
    begin
      count <= next_count;
      wrap <= next_wrap;
    end
  end

  assign count_o = count;
  assign wrap_o = wrap;
endmodule
`default_nettype wire
